// ==== include/umfi_defines.svh ====
// offsets, field positions and reset values of the uart modem, fifo and interrupt block
`ifndef UMFI_DEFINES_SVH
`define UMFI_DEFINES_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define UMFI_IDX_DATA   3'h0
`define UMFI_IDX_IEN    3'h1
`define UMFI_IDX_IDFC   3'h2
`define UMFI_IDX_LCTL   3'h3
`define UMFI_IDX_MCTL   3'h4
`define UMFI_IDX_LSTAT  3'h5
`define UMFI_IDX_MSTAT  3'h6
`define UMFI_IDX_SCR    3'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UMFI_MC_DTR     0
`define UMFI_MC_RTS     1
`define UMFI_MC_RI      2
`define UMFI_MC_IRQEN   3
`define UMFI_MC_LOOP    4
`define UMFI_FC_EN      0
`define UMFI_FC_RXRST   1
`define UMFI_FC_TXRST   2
`define UMFI_FC_DMA     3
`define UMFI_FC_TRIG    7:6

// ------------------------------------------------------------
// reset values, thresholds and interrupt codes
// ------------------------------------------------------------
`define UMFI_MC_RST     5'h00
`define UMFI_IE_RST     4'h0
`define UMFI_TRIG_0     5'h01
`define UMFI_TRIG_1     5'h04
`define UMFI_TRIG_2     5'h08
`define UMFI_TRIG_3     5'h0e
`define UMFI_TO_CHARS   3'h4
`define UMFI_ID_NONE    4'h1
`define UMFI_ID_LINE    4'h6
`define UMFI_ID_RXDATA  4'h4
`define UMFI_ID_TMO     4'hc
`define UMFI_ID_TXE     4'h2
`define UMFI_ID_MODEM   4'h0

`endif

// ==== include/umfi_pkg.sv ====
// types shared by the uart modem, fifo and interrupt block
package umfi_pkg;

  // ------------------------------------------------------------
  // bus phase and block state
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    APB_WAIT,
    APB_DONE
  } umfi_apb_e;

  typedef struct packed {
    umfi_apb_e   ph;
    logic [31:0] prdata;
    logic        pslverr;
    logic [4:0]  mctl;
    logic [3:0]  ien;
    logic        fifo_en;
    logic        dma;
    logic [1:0]  trig;
    logic        armed;
    logic [3:0]  mprev;
    logic [3:0]  mflag;
    logic [3:0]  lerr;
    logic        txe;
    logic [2:0]  to_cnt;
    logic        rx_rst;
    logic        tx_rst;
    logic        rd_rx;
    logic        wr_tx;
    logic [7:0]  tx_data;
    logic        serial_out;
    logic        rx_ser;
    logic        rts_b;
    logic        dtr_b;
    logic        irq;
  } umfi_state_s;

endpackage : umfi_pkg

// ==== hdl/umfi_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module umfi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } umfi_sync_s;

  umfi_sync_s st;
  umfi_sync_s next_st;

  // ------------------------------------------------------------
  // stages; the first one is read by the second alone
  // ------------------------------------------------------------
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // idle pins are high, so reset to ones avoids a false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule : umfi_sync

// ==== hdl/umfi_top.sv ====
// uart modem handshake, loopback, fifo control and interrupt identification with apb registers
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "umfi_defines.svh"

module umfi_top #(
  parameter int ADDR_W = 12,
  parameter int LVL_W  = 5
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // receive side of the uart
  input  wire logic [7:0]        RX_DATA,
  input  wire logic              RX_READY,
  input  wire logic [LVL_W-1:0]  RX_LEVEL,
  input  wire logic              RX_PUSH,
  input  wire logic              CHAR_TICK,
  input  wire logic              ERR_OVERRUN,
  input  wire logic              ERR_PARITY,
  input  wire logic              ERR_FRAMING,
  input  wire logic              ERR_SILENT,
  output logic                   RX_READ,
  output logic                   RX_FIFO_CLR,
  output logic                   RX_SERIAL,
  // transmit side of the uart
  input  wire logic              TX_EMPTY_SET,
  input  wire logic              TX_BUF_EMPTY,
  input  wire logic              TX_SHIFT_EMPTY,
  input  wire logic              TX_SERIAL,
  output logic                   TX_WRITE,
  output logic      [7:0]        TX_DATA,
  output logic                   TX_FIFO_CLR,
  output logic                   FIFO_MODE,
  output logic                   DMA_MODE,
  // pins
  input  wire logic              SERIAL_IN,
  input  wire logic              CTS_B,
  input  wire logic              DSR_B,
  input  wire logic              RI_B,
  input  wire logic              DCD_B,
  output logic                   SERIAL_OUT,
  output logic                   RTS_B,
  output logic                   DTR_B,
  output logic                   IRQ
);
  import umfi_pkg::*;

  umfi_state_s st;
  umfi_state_s next_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // receive threshold in bytes for a trigger selection
  function automatic logic [LVL_W-1:0] trig_bytes(input logic [1:0] sel);
    logic [4:0] b;
    b = `UMFI_TRIG_0;
    case (sel)
      2'h1: b = `UMFI_TRIG_1;
      2'h2: b = `UMFI_TRIG_2;
      2'h3: b = `UMFI_TRIG_3;
      default: b = `UMFI_TRIG_0;
    endcase
    return LVL_W'(b);
  endfunction : trig_bytes

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_q;

  umfi_sync #(
    .W (5)
  ) u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({SERIAL_IN, DCD_B, RI_B, DSR_B, CTS_B}),
    .q     (pin_q)
  );

  // ------------------------------------------------------------
  // modem inputs, order {dcd, ri, dsr, cts}, active high
  // ------------------------------------------------------------
  logic       loop;
  logic [3:0] modem_in;
  logic [3:0] mset;

  assign loop = st.mctl[`UMFI_MC_LOOP];
  // loopback routes control bits in place of the cut pins
  assign modem_in = loop ? {st.mctl[`UMFI_MC_IRQEN], st.mctl[`UMFI_MC_RI],
                            st.mctl[`UMFI_MC_DTR], st.mctl[`UMFI_MC_RTS]}
                         : ~pin_q[3:0];
  // toggles for dcd, dsr, cts; trailing edge for ri
  assign mset = st.armed ? {modem_in[3] ^ st.mprev[3],
                            st.mprev[2] & ~modem_in[2],
                            modem_in[1:0] ^ st.mprev[1:0]}
                         : 4'h0;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic [2:0] idx;
  logic       mapped;
  logic       acc;
  logic       done;
  logic       rd;
  logic       wr;

  assign idx = PADDR[4:2];
  // line control and scratch live elsewhere, so they answer with an error
  always_comb begin
    if (PADDR[ADDR_W-1:5] != '0 || PADDR[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx == `UMFI_IDX_LCTL || idx == `UMFI_IDX_SCR) begin
      mapped = 1'b0;
    end else begin
      mapped = 1'b1;
    end
  end

  assign acc  = PSEL & PENABLE & (st.ph == APB_WAIT);
  assign done = PSEL & PENABLE & (st.ph == APB_DONE);
  // read side effects act as the data is captured so no event slips between
  assign rd   = acc & ~PWRITE & mapped;
  assign wr   = done & PWRITE & mapped;

  // ------------------------------------------------------------
  // interrupt sources and identification
  // ------------------------------------------------------------
  logic       p_line;
  logic       p_rxd;
  logic       p_tmo;
  logic       p_txe;
  logic       p_mod;
  logic [3:0] id;

  assign p_line = st.ien[2] & (|st.lerr);
  assign p_rxd  = st.ien[0] & (st.fifo_en ? (RX_LEVEL >= trig_bytes(st.trig))
                                          : RX_READY);
  assign p_tmo  = st.ien[0] & st.fifo_en & (st.to_cnt == `UMFI_TO_CHARS);
  assign p_txe  = st.ien[1] & st.txe;
  assign p_mod  = st.ien[3] & (|st.mflag);

  // only the highest pending source is reported
  always_comb begin
    if (p_line) begin
      id = `UMFI_ID_LINE;
    end else if (p_rxd) begin
      id = `UMFI_ID_RXDATA;
    end else if (p_tmo) begin
      id = `UMFI_ID_TMO;
    end else if (p_txe) begin
      id = `UMFI_ID_TXE;
    end else if (p_mod) begin
      id = `UMFI_ID_MODEM;
    end else begin
      id = `UMFI_ID_NONE;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] rdat;
    logic       fc_chg;
    rdat    = 8'h00;
    fc_chg  = 1'b0;
    next_st = st;

    // read data mux; reserved bits stay zero
    if (idx == `UMFI_IDX_DATA) begin
      rdat = RX_DATA;
    end else if (idx == `UMFI_IDX_IEN) begin
      rdat = {4'h0, st.ien};
    end else if (idx == `UMFI_IDX_IDFC) begin
      rdat = {{2{st.fifo_en}}, 2'h0, id};
    end else if (idx == `UMFI_IDX_MCTL) begin
      rdat = {3'h0, st.mctl};
    end else if (idx == `UMFI_IDX_LSTAT) begin
      rdat = {1'b0, TX_SHIFT_EMPTY, TX_BUF_EMPTY, st.lerr, RX_READY};
    end else if (idx == `UMFI_IDX_MSTAT) begin
      rdat = {modem_in, st.mflag};
    end else begin
      rdat = 8'h00;
    end

    // one wait state: capture in the first access cycle, complete next
    if (acc) begin
      next_st.ph      = APB_DONE;
      next_st.prdata  = {24'h0, PWRITE ? 8'h00 : rdat};
      next_st.pslverr = ~mapped;
    end else begin
      next_st.ph      = APB_WAIT;
      next_st.prdata  = 32'h0;
      next_st.pslverr = 1'b0;
    end

    // one-cycle strobes default low
    next_st.rx_rst = 1'b0;
    next_st.tx_rst = 1'b0;
    next_st.rd_rx  = rd & (idx == `UMFI_IDX_DATA);
    next_st.wr_tx  = wr & (idx == `UMFI_IDX_DATA);

    // register writes
    if (wr && idx == `UMFI_IDX_DATA) begin
      next_st.tx_data = PWDATA[7:0];
    end
    if (wr && idx == `UMFI_IDX_IEN) begin
      next_st.ien = PWDATA[3:0];
    end
    if (wr && idx == `UMFI_IDX_MCTL) begin
      next_st.mctl = PWDATA[4:0];
    end
    if (wr && idx == `UMFI_IDX_IDFC) begin
      // toggling fifo mode flushes both fifos
      fc_chg          = PWDATA[`UMFI_FC_EN] ^ st.fifo_en;
      next_st.fifo_en = PWDATA[`UMFI_FC_EN];
      next_st.dma     = PWDATA[`UMFI_FC_DMA] & PWDATA[`UMFI_FC_EN];
      next_st.rx_rst  = PWDATA[`UMFI_FC_RXRST] | fc_chg;
      next_st.tx_rst  = PWDATA[`UMFI_FC_TXRST] | fc_chg;
      // threshold only taken together with fifo enable
      if (PWDATA[`UMFI_FC_EN]) begin
        next_st.trig = PWDATA[`UMFI_FC_TRIG];
      end
    end

    // modem change flags; a new change beats the read that clears
    next_st.armed = 1'b1;
    next_st.mprev = modem_in;
    next_st.mflag = ((rd && idx == `UMFI_IDX_MSTAT) ? 4'h0 : st.mflag) | mset;

    // line error flags, cleared by a line status read, set wins
    next_st.lerr = ((rd && idx == `UMFI_IDX_LSTAT) ? 4'h0 : st.lerr) |
                   {ERR_SILENT, ERR_FRAMING, ERR_PARITY, ERR_OVERRUN};

    // transmit empty flag
    if (TX_EMPTY_SET) begin
      next_st.txe = 1'b1;
    end else if (wr && idx == `UMFI_IDX_DATA) begin
      next_st.txe = 1'b0;
    end else if (rd && idx == `UMFI_IDX_IDFC && id == `UMFI_ID_TXE) begin
      next_st.txe = 1'b0;
    end

    // receive timeout: count character times with no fifo access
    if (!st.fifo_en || RX_LEVEL == '0 || RX_PUSH || st.rx_rst ||
        (rd && idx == `UMFI_IDX_DATA)) begin
      next_st.to_cnt = 3'h0;
    end else if (CHAR_TICK && st.to_cnt != `UMFI_TO_CHARS) begin
      next_st.to_cnt = st.to_cnt + 3'h1;
    end

    // serial path and modem outputs
    next_st.serial_out   = loop ? 1'b1 : TX_SERIAL;
    next_st.rx_ser = loop ? TX_SERIAL : pin_q[4];
    next_st.rts_b  = loop ? 1'b1 : ~st.mctl[`UMFI_MC_RTS];
    next_st.dtr_b  = loop ? 1'b1 : ~st.mctl[`UMFI_MC_DTR];

    // interrupt output
    next_st.irq = st.mctl[`UMFI_MC_IRQEN] & (id != `UMFI_ID_NONE);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // modem pins idle inactive high, serial lines idle at mark
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st        <= '0;
      st.ph     <= APB_WAIT;
      st.mctl   <= `UMFI_MC_RST;
      st.ien    <= `UMFI_IE_RST;
      st.serial_out   <= 1'b1;
      st.rx_ser <= 1'b1;
      st.rts_b  <= 1'b1;
      st.dtr_b  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from state
  // ------------------------------------------------------------
  assign PRDATA      = st.prdata;
  assign PREADY      = (st.ph == APB_DONE);
  assign PSLVERR     = st.pslverr;
  assign RX_READ     = st.rd_rx;
  assign RX_FIFO_CLR = st.rx_rst;
  assign RX_SERIAL   = st.rx_ser;
  assign TX_WRITE    = st.wr_tx;
  assign TX_DATA     = st.tx_data;
  assign TX_FIFO_CLR = st.tx_rst;
  assign FIFO_MODE   = st.fifo_en;
  assign DMA_MODE    = st.dma;
  assign SERIAL_OUT  = st.serial_out;
  assign RTS_B       = st.rts_b;
  assign DTR_B       = st.dtr_b;
  assign IRQ         = st.irq;

endmodule : umfi_top

// ==== bench/umfi_sva.sv ====
// assertion checker for the uart modem, fifo and interrupt block
`timescale 1ns/1ps

module umfi_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic              REF_CLK,
  input wire logic              RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              RX_READ,
  input wire logic              RX_FIFO_CLR,
  input wire logic              FIFO_MODE,
  input wire logic              DMA_MODE,
  input wire logic              SERIAL_OUT,
  input wire logic              RTS_B,
  input wire logic              DTR_B,
  input wire logic              IRQ
);
  logic [4:0] mc;
  logic [3:0] ien;
  logic       fen;
  logic       wr;
  logic       rd;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // shadow copies of written controls, taken at the completing edge
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign rd = PSEL && PENABLE && PREADY && !PWRITE;
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      mc  <= 5'h00;
      ien <= 4'h0;
      fen <= 1'b0;
    end else if (wr) begin
      if (PADDR == 12'h010) mc <= PWDATA[4:0];
      if (PADDR == 12'h004) ien <= PWDATA[3:0];
      if (PADDR == 12'h008) fen <= PWDATA[0];
    end
  end

  a_loop_pins_idle: assert property (mc[4] && $past(mc[4]) |->
    SERIAL_OUT && RTS_B && DTR_B) else $error("loopback pins not idle");
  a_pins_follow: assert property (!mc[4] && mc == $past(mc) |->
    RTS_B == !mc[1] && DTR_B == !mc[0]) else $error("rts or dtr wrong");
  a_irq_gate: assert property (!mc[3] && !$past(mc[3]) |-> !IRQ)
    else $error("irq while output disabled");
  a_ien_zero: assert property (ien == 4'h0 && $past(ien) == 4'h0 |-> !IRQ)
    else $error("irq with all enables off");
  a_upper_zero: assert property (rd && (PADDR == 12'h010 || PADDR == 12'h004) |->
    (PRDATA >> (PADDR == 12'h010 ? 5 : 4)) == 32'h0) else $error("unused bits set");
  a_fifo_id: assert property (rd && PADDR == 12'h008 |-> PRDATA[7:6] == {2{fen}})
    else $error("fifo bits of id wrong");
  a_id_bit3: assert property (rd && PADDR == 12'h008 && !fen |-> !PRDATA[3])
    else $error("timeout code outside fifo mode");
  a_fifo_mode: assert property (fen == $past(fen) |-> FIFO_MODE == fen)
    else $error("fifo mode output wrong");
  a_dma_off: assert property (!fen && !$past(fen) |-> !DMA_MODE)
    else $error("dma mode 1 without fifo mode");
  a_rxclr_pulse: assert property (wr && PADDR == 12'h008 && PWDATA[1] |=>
    RX_FIFO_CLR ##1 !RX_FIFO_CLR) else $error("rx fifo clear not one pulse");
  a_rx_read: assert property (PSEL && PENABLE && !PREADY && !PWRITE && PADDR == 12'h0 |=>
    RX_READ ##1 !RX_READ) else $error("receive read pulse wrong");
endmodule : umfi_sva

// ==== bench/umfi_modem_peer.sv ====
// modem side model driving the handshake inputs and the serial line
`timescale 1ns/1ps

module umfi_modem_peer (
  input  wire logic       clk,
  input  wire logic [3:0] want,
  input  wire logic       slow,
  input  wire logic       line_bit,
  output logic            dcd_b,
  output logic            ri_b,
  output logic            dsr_b,
  output logic            cts_b,
  output logic            serial_in
);
  logic [3:0] cur = 4'h0;
  logic [2:0] dly = 3'h0;

  // a real modem answers late at times, so a change may lag some cycles
  always @(posedge clk) begin
    if (want == cur)
      dly <= 3'h0;
    else if (dly >= (slow ? 3'h5 : 3'h1)) begin
      cur <= want;
      dly <= 3'h0;
    end else
      dly <= dly + 3'h1;
  end

  // handshake lines are active low on the wire
  assign {dcd_b, ri_b, dsr_b, cts_b} = ~cur;
  assign serial_in = line_bit;
endmodule : umfi_modem_peer

// ==== bench/umfi_tb_top.sv ====
// self-checking testbench of the uart modem, fifo and interrupt block
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h expected %h", $time, (g), (e)); end end

module umfi_tb_top;
  typedef struct { logic [31:0] d; logic [31:0] m; logic e; } umfi_note_s;
  logic        REF_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rs = 32'h899c, d;
  logic        PREADY, PSLVERR, RX_READ, RX_FIFO_CLR, RX_SERIAL, TX_WRITE, TX_FIFO_CLR;
  logic        FIFO_MODE, DMA_MODE, SERIAL_IN, CTS_B, DSR_B, RI_B, DCD_B;
  logic        SERIAL_OUT, RTS_B, DTR_B, IRQ;
  logic [7:0]  RX_DATA = '0, TX_DATA, m;
  logic [4:0]  RX_LEVEL = '0;
  logic [4:0]  thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  logic        RX_READY = 1'b0, RX_PUSH = 1'b0, CHAR_TICK = 1'b0, TX_EMPTY_SET = 1'b0;
  logic        TX_BUF_EMPTY = 1'b0, TX_SHIFT_EMPTY = 1'b0, TX_SERIAL = 1'b1;
  logic        line_bit = 1'b1, slow = 1'b0;
  logic [3:0]  errs = '0, want = '0, k4;
  int          fail_count = 0, checks = 0;
  umfi_note_s  q[$];
  umfi_note_s  note;

  umfi_top i_umfi_top (.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_DATA(RX_DATA), .RX_READY(RX_READY), .RX_LEVEL(RX_LEVEL),
    .RX_PUSH(RX_PUSH), .CHAR_TICK(CHAR_TICK), .ERR_OVERRUN(errs[0]), .ERR_PARITY(errs[1]),
    .ERR_FRAMING(errs[2]), .ERR_SILENT(errs[3]), .RX_READ(RX_READ), .RX_FIFO_CLR(RX_FIFO_CLR),
    .RX_SERIAL(RX_SERIAL), .TX_EMPTY_SET(TX_EMPTY_SET), .TX_BUF_EMPTY(TX_BUF_EMPTY),
    .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .TX_SERIAL(TX_SERIAL), .TX_WRITE(TX_WRITE),
    .TX_DATA(TX_DATA), .TX_FIFO_CLR(TX_FIFO_CLR), .FIFO_MODE(FIFO_MODE), .DMA_MODE(DMA_MODE),
    .SERIAL_IN(SERIAL_IN), .CTS_B(CTS_B), .DSR_B(DSR_B), .RI_B(RI_B), .DCD_B(DCD_B),
    .SERIAL_OUT(SERIAL_OUT), .RTS_B(RTS_B), .DTR_B(DTR_B), .IRQ(IRQ));
  umfi_modem_peer i_umfi_modem_peer (.clk(REF_CLK), .want(want), .slow(slow),
    .line_bit(line_bit), .dcd_b(DCD_B), .ri_b(RI_B), .dsr_b(DSR_B), .cts_b(CTS_B),
    .serial_in(SERIAL_IN));

  // 250 MHz clock
  always #2 REF_CLK = ~REF_CLK;

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic tick(input int c);
    repeat (c) @(posedge REF_CLK);
  endtask : tick

  // one apb transfer; the expected answer is queued before the request starts
  task automatic xfer(input logic w, input logic [2:0] i, input logic [7:0] dt,
                      input logic [31:0] ex, input logic [31:0] mk);
    int n;
    q.push_back('{ex, w ? 32'h0 : mk, i == 3'h3 || i == 3'h7});
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= {7'h00, i, 2'h0};
    PWDATA  <= {rnd() & 32'hffffff00} | {24'h0, dt};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      end_of_test();
    end
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [2:0] i, input logic [7:0] dt);
    xfer(1'b1, i, dt, '0, '0);
  endtask : wr

  task automatic rd(input logic [2:0] i, input logic [31:0] ex);
    xfer(1'b0, i, 8'h00, ex, '1);
  endtask : rd

  // answers are matched in order against the queued notes
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      `CHK(PRDATA & note.m, note.d & note.m)
      `CHK(PSLVERR, note.e)
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(16);
    RST_B <= 1'b1;
    rd(3'h4, 32'h0);
    rd(3'h2, 32'h01);
    rd(3'h3, 32'h0);
    wr(3'h7, 8'hff);
    // register masks and the handshake output pins, loopback kept off
    for (int k = 0; k < 6; k++) begin
      d = rnd();
      m = d[7:0] & 8'hef;
      wr(3'h4, m);
      rd(3'h4, {24'h0, m & 8'h1f});
      tick(3);
      `CHK({RTS_B, DTR_B}, ~m[1:0])
      wr(3'h1, d[15:8]);
      rd(3'h1, {24'h0, d[15:8] & 8'h0f});
    end
    // pin changes with the interrupt masked, then enabled, then gated
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h08);
    want <= 4'hf;
    slow <= 1'b1;
    tick(16);
    `CHK(IRQ, 1'b0)
    rd(3'h2, 32'h01);
    rd(3'h6, 32'hfb);
    rd(3'h6, 32'hf0);
    wr(3'h1, 8'h08);
    want <= 4'h0;
    slow <= 1'b0;
    tick(12);
    `CHK(IRQ, 1'b1)
    rd(3'h2, 32'h00);
    rd(3'h6, 32'h0f);
    tick(3);
    `CHK(IRQ, 1'b0)
    want <= 4'h1;
    tick(12);
    wr(3'h4, 8'h00);
    tick(3);
    `CHK(IRQ, 1'b0)
    rd(3'h2, 32'h00);
    rd(3'h6, 32'h11);
    // loopback over every setting of the four looped control bits
    for (int k = 0; k < 16; k++) begin
      k4 = k[3:0];
      d = rnd();
      TX_SERIAL <= d[0];
      line_bit  <= ~d[0];
      wr(3'h4, {4'h1, k4});
      tick(6);
      `CHK({SERIAL_OUT, RTS_B, DTR_B}, 3'h7)
      `CHK(RX_SERIAL, d[0])
      xfer(1'b0, 3'h6, 8'h00, {24'h0, k4[3], k4[2], k4[0], k4[1], 4'h0}, 32'hf0);
    end
    wr(3'h4, 8'h00);
    tick(6);
    `CHK({SERIAL_OUT, RX_SERIAL}, {TX_SERIAL, line_bit})
    xfer(1'b0, 3'h6, 8'h00, '0, '0);
    // line errors, receive ready, transmit empty and priority order
    {TX_BUF_EMPTY, TX_SHIFT_EMPTY, RX_DATA} <= d[17:8];
    RX_READY <= 1'b1;
    wr(3'h1, 8'h0f);
    for (int k = 0; k < 4; k++) begin
      errs <= 4'h1 << k;
      tick(1);
      errs <= 4'h0;
      rd(3'h2, 32'h06);
      rd(3'h5, {25'h0, TX_SHIFT_EMPTY, TX_BUF_EMPTY, 4'h1 << k, 1'b1});
      rd(3'h2, 32'h04);
    end
    rd(3'h0, {24'h0, RX_DATA});
    RX_READY <= 1'b0;
    TX_EMPTY_SET <= 1'b1;
    want <= 4'h0;
    tick(1);
    TX_EMPTY_SET <= 1'b0;
    tick(12);
    rd(3'h2, 32'h02);
    rd(3'h2, 32'h00);
    rd(3'h6, 32'h01);
    TX_EMPTY_SET <= 1'b1;
    tick(1);
    TX_EMPTY_SET <= 1'b0;
    rd(3'h2, 32'h02);
    wr(3'h0, d[31:24]);
    #1 `CHK({TX_WRITE, TX_DATA}, {1'b1, d[31:24]})
    rd(3'h2, 32'h01);
    // fifo mode first, then dma, resets, thresholds and timeout
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h01);
    rd(3'h2, 32'hc1);
    wr(3'h2, 8'h09);
    tick(2);
    `CHK(DMA_MODE, 1'b1)
    wr(3'h2, 8'h08);
    tick(2);
    `CHK({FIFO_MODE, DMA_MODE}, 2'h0)
    rd(3'h2, 32'h01);
    wr(3'h2, 8'h01);
    wr(3'h2, 8'h07);
    #1 `CHK({TX_FIFO_CLR, RX_FIFO_CLR}, 2'h3)
    tick(1);
    #1 `CHK({TX_FIFO_CLR, RX_FIFO_CLR}, 2'h0)
    for (int t = 0; t < 4; t++) begin
      wr(3'h2, {t[1:0], 6'h01});
      RX_LEVEL <= thr[t] - 5'h01;
      tick(3);
      rd(3'h2, 32'hc1);
      RX_LEVEL <= thr[t];
      tick(3);
      rd(3'h2, 32'hc4);
    end
    RX_LEVEL <= 5'h01;
    for (int k = 0; k < 7; k++) begin
      RX_PUSH   <= (k == 2);
      CHAR_TICK <= (k != 2);
      tick(1);
      RX_PUSH   <= 1'b0;
      CHAR_TICK <= 1'b0;
      tick(1);
      if (k == 5) rd(3'h2, 32'hc1);
    end
    rd(3'h2, 32'hcc);
    rd(3'h0, {24'h0, RX_DATA});
    rd(3'h2, 32'hc1);
    // let the monitor take the last answer before the verdict
    tick(1);
    end_of_test();
  end
endmodule : umfi_tb_top

bind umfi_top umfi_sva #(.ADDR_W(ADDR_W)) i_umfi_sva (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .RX_READ(RX_READ), .RX_FIFO_CLR(RX_FIFO_CLR),
  .FIFO_MODE(FIFO_MODE), .DMA_MODE(DMA_MODE), .SERIAL_OUT(SERIAL_OUT), .RTS_B(RTS_B),
  .DTR_B(DTR_B), .IRQ(IRQ));
